// File: lbrc_pkg.sv
// package: register map, field layout, reset values and ramp-time table
package lbrc_pkg;

    // ==========================================================
    // register offsets
    localparam logic [7:0] ADDR_REVISION = 8'h00;
    localparam logic [7:0] ADDR_SOFT_RESET = 8'h01;
    localparam logic [7:0] ADDR_HV_ROUTING = 8'h10;
    localparam logic [7:0] ADDR_LV_ROUTING = 8'h11;
    localparam logic [7:0] ADDR_ONOFF_A = 8'h12;
    localparam logic [7:0] ADDR_ONOFF_B = 8'h13;
    localparam logic [7:0] ADDR_ONOFF_C = 8'h14;
    localparam logic [7:0] ADDR_ONOFF_H = 8'h19;
    localparam logic [7:0] ADDR_AB_RUNTIME = 8'h1A;
    localparam logic [7:0] ADDR_AB_SELECT = 8'h1B;
    localparam logic [7:0] ADDR_CDE_RUNTIME = 8'h1C;
    localparam logic [7:0] ADDR_FGH_RUNTIME = 8'h1D;
    localparam logic [7:0] ADDR_DITHER_MAP = 8'h1F;

    // ==========================================================
    // writable-bit masks and the read-only revision mask; everything else reads zero
    localparam logic [7:0] MASK_REVISION = 8'h0F;
    localparam logic [7:0] MASK_HV_ROUTING = 8'h07;
    localparam logic [7:0] MASK_LV_ROUTING = 8'h36;
    localparam logic [7:0] MASK_WIDE_RAMP = 8'hFF;
    localparam logic [7:0] MASK_NARROW_RAMP = 8'h77;
    localparam logic [7:0] MASK_AB_SELECT = 8'h0F;
    localparam logic [7:0] MASK_DITHER_MAP = 8'h0F;

    // ==========================================================
    // reset values
    localparam logic [7:0] RST_HV_ROUTING = 8'h06;
    localparam logic [7:0] RST_LV_ROUTING = 8'h36;
    localparam logic [7:0] RST_RAMP = 8'h00;
    localparam logic [7:0] RST_AB_SELECT = 8'h00;
    localparam logic [7:0] RST_DITHER_MAP = 8'h00;

    // ==========================================================
    // field positions
    localparam int SOFT_RESET_BIT = 0;
    localparam int UP_LSB = 4;
    localparam int DOWN_LSB = 0;
    localparam int SEL_A_LSB = 0;
    localparam int SEL_B_LSB = 2;
    localparam int MAP_AB_BIT = 0;
    localparam int MAP_CH_BIT = 1;
    localparam int DITHER_A_BIT = 2;
    localparam int DITHER_B_BIT = 3;
    localparam int NUM_NARROW_BANKS = 6;

    // ==========================================================
    // ramp selector codes
    localparam logic [1:0] SEL_RUNTIME = 2'h0;
    localparam logic [1:0] SEL_ONOFF = 2'h1;

    // ==========================================================
    // ramp-time table in microseconds
    localparam int unsigned RAMP_US_0 = 2048;
    localparam int unsigned RAMP_US_1 = 262000;
    localparam int unsigned RAMP_US_2 = 524000;
    localparam int unsigned RAMP_US_3 = 1049000;
    localparam int unsigned RAMP_US_4 = 2097000;
    localparam int unsigned RAMP_US_5 = 4194000;
    localparam int unsigned RAMP_US_6 = 8389000;
    localparam int unsigned RAMP_US_7 = 16780000;
    localparam int unsigned RAMP_US_8 = 33550000;
    localparam int unsigned RAMP_US_9 = 41940000;
    localparam int unsigned RAMP_US_10 = 50330000;
    localparam int unsigned RAMP_US_11 = 58720000;
    localparam int unsigned RAMP_US_12 = 67110000;
    localparam int unsigned RAMP_US_13 = 83880000;
    localparam int unsigned RAMP_US_14 = 100660000;
    localparam int unsigned RAMP_US_15 = 117440000;

    // ==========================================================
    // resolved ramp setting for one bank
    typedef struct packed {
        logic disabled;
        logic [3:0] up_code;
        logic [3:0] down_code;
    } lbrc_ramp_s;

    // register port
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } lbrc_req_s;

endpackage

// File: lbrc_top.sv
// led bank routing and ramp configuration register bank
//
// Operation
// - the revision register returns a fixed 4-bit revision in bits 3:0, upper bits zero.
// - writing one to bit 0 of the reset register starts a software reset and the bit then clears.
// - each high-voltage sink has a bank A/B select bit, sink 1 defaulting to A and sinks 2, 3 to B.
// - low-voltage sink 6 selects F or H by bit 5 and sink 5 F or G by bit 4, defaults H and G.
// - low-voltage sink 3 selects C or E by bit 2 and sink 2 C or D by bit 1, defaults E and D.
// - banks A and B hold a 4-bit start-up code in 7:4 and a 4-bit shutdown code in 3:0.
// - banks C to H hold a 3-bit start-up code in 6:4 and a 3-bit shutdown code in 2:0.
// - a shared A/B run-time register holds a 4-bit ramp-up and 4-bit ramp-down code.
// - a 2-bit selector per bank A/B picks run-time times, start/shutdown times, or no ramp.
// - banks C-E and F-H each share a run-time register of 3-bit up and down codes.
// - bank A and B dithering runs while their disable bits are zero.
// - mapping is exponential when zero and linear when one, for A/B and for C-H.
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps

module lbrc_top #(
    parameter logic [3:0] SILICON_REV = 4'h1 // arbitrary revision value
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic soft_reset_pulse,
    output logic [2:0] hv_sink_to_bank_b,
    output logic [3:0] lv_sink_select,
    output lbrc_pkg::lbrc_ramp_s [7:0] onoff_ramp,
    output lbrc_pkg::lbrc_ramp_s [7:0] active_ramp,
    output logic dither_a_en,
    output logic dither_b_en,
    output logic map_ab_linear,
    output logic map_ch_linear
);

    // ==========================================================
    // state
    typedef struct packed {
        logic [7:0] rdata;
        logic srst;
        logic [7:0] hv_route;
        logic [7:0] lv_route;
        logic [7:0][7:0] onoff;
        logic [7:0] ab_run;
        logic [7:0] ab_sel;
        logic [7:0] cde_run;
        logic [7:0] fgh_run;
        logic [7:0] dmap;
        logic dith_a_en;
        logic dith_b_en;
        lbrc_pkg::lbrc_ramp_s [7:0] onoff_o;
        lbrc_pkg::lbrc_ramp_s [7:0] active_o;
    } lbrc_state_s;

    lbrc_state_s st_q;
    lbrc_state_s st_d;

    // ==========================================================
    // helpers
    function automatic lbrc_pkg::lbrc_ramp_s lbrc_ramp(
        input logic dis, input logic [7:0] r);
        lbrc_pkg::lbrc_ramp_s v;
        v.disabled = dis;
        v.up_code = r[lbrc_pkg::UP_LSB +: 4];
        v.down_code = r[lbrc_pkg::DOWN_LSB +: 4];
        return v;
    endfunction

    function automatic lbrc_pkg::lbrc_ramp_s lbrc_select(
        input logic [1:0] sel, input logic [7:0] run,
        input logic [7:0] onoff);
        lbrc_pkg::lbrc_ramp_s v;
        v = lbrc_ramp(1'b0, run);
        case (sel)
            lbrc_pkg::SEL_RUNTIME: v = lbrc_ramp(1'b0, run);
            lbrc_pkg::SEL_ONOFF: v = lbrc_ramp(1'b0, onoff);
            default: v = lbrc_ramp(1'b1, 8'h00);
        endcase
        return v;
    endfunction

    // ==========================================================
    // next state
    always_comb begin
        int i;
        logic [7:0] idx;
        i = 0;
        idx = 8'h00;
        st_d = st_q;
        st_d.srst = 1'b0;
        if (st_q.srst) begin
            // a software reset clears the ramp codes and selectors
            for (i = 0; i < 8; i++) begin
                st_d.onoff[i] = lbrc_pkg::RST_RAMP;
            end
            st_d.ab_run = lbrc_pkg::RST_RAMP;
            st_d.cde_run = lbrc_pkg::RST_RAMP;
            st_d.fgh_run = lbrc_pkg::RST_RAMP;
            st_d.ab_sel = lbrc_pkg::RST_AB_SELECT;
            st_d.hv_route = lbrc_pkg::RST_HV_ROUTING;
            st_d.lv_route = lbrc_pkg::RST_LV_ROUTING;
            st_d.dmap = lbrc_pkg::RST_DITHER_MAP;
        end else if (reg_wr) begin
            case (reg_addr)
                lbrc_pkg::ADDR_SOFT_RESET:
                    st_d.srst = reg_wdata[lbrc_pkg::SOFT_RESET_BIT];
                lbrc_pkg::ADDR_HV_ROUTING:
                    st_d.hv_route = reg_wdata & lbrc_pkg::MASK_HV_ROUTING;
                lbrc_pkg::ADDR_LV_ROUTING:
                    st_d.lv_route = reg_wdata & lbrc_pkg::MASK_LV_ROUTING;
                lbrc_pkg::ADDR_ONOFF_A, lbrc_pkg::ADDR_ONOFF_B: begin
                    idx = reg_addr - lbrc_pkg::ADDR_ONOFF_A;
                    st_d.onoff[idx[2:0]] = reg_wdata & lbrc_pkg::MASK_WIDE_RAMP;
                end
                lbrc_pkg::ADDR_AB_RUNTIME:
                    st_d.ab_run = reg_wdata & lbrc_pkg::MASK_WIDE_RAMP;
                lbrc_pkg::ADDR_AB_SELECT:
                    st_d.ab_sel = reg_wdata & lbrc_pkg::MASK_AB_SELECT;
                lbrc_pkg::ADDR_CDE_RUNTIME:
                    st_d.cde_run = reg_wdata & lbrc_pkg::MASK_NARROW_RAMP;
                lbrc_pkg::ADDR_FGH_RUNTIME:
                    st_d.fgh_run = reg_wdata & lbrc_pkg::MASK_NARROW_RAMP;
                lbrc_pkg::ADDR_DITHER_MAP:
                    st_d.dmap = reg_wdata & lbrc_pkg::MASK_DITHER_MAP;
                default: begin
                    if (reg_addr >= lbrc_pkg::ADDR_ONOFF_C &&
                        reg_addr <= lbrc_pkg::ADDR_ONOFF_H) begin
                        idx = reg_addr - lbrc_pkg::ADDR_ONOFF_A;
                        st_d.onoff[idx[2:0]] =
                            reg_wdata & lbrc_pkg::MASK_NARROW_RAMP;
                    end
                end
            endcase
        end

        // enables kept as flops so the pins carry no inverter
        st_d.dith_a_en = ~st_d.dmap[lbrc_pkg::DITHER_A_BIT];
        st_d.dith_b_en = ~st_d.dmap[lbrc_pkg::DITHER_B_BIT];

        // read data: valid the cycle after the strobe only
        st_d.rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                lbrc_pkg::ADDR_REVISION:
                    st_d.rdata = {4'h0, SILICON_REV} & lbrc_pkg::MASK_REVISION;
                lbrc_pkg::ADDR_SOFT_RESET: st_d.rdata = {7'h00, st_q.srst};
                lbrc_pkg::ADDR_HV_ROUTING: st_d.rdata = st_q.hv_route;
                lbrc_pkg::ADDR_LV_ROUTING: st_d.rdata = st_q.lv_route;
                lbrc_pkg::ADDR_AB_RUNTIME: st_d.rdata = st_q.ab_run;
                lbrc_pkg::ADDR_AB_SELECT: st_d.rdata = st_q.ab_sel;
                lbrc_pkg::ADDR_CDE_RUNTIME: st_d.rdata = st_q.cde_run;
                lbrc_pkg::ADDR_FGH_RUNTIME: st_d.rdata = st_q.fgh_run;
                lbrc_pkg::ADDR_DITHER_MAP: st_d.rdata = st_q.dmap;
                default: begin
                    // unmapped and reserved addresses read zero
                    if (reg_addr >= lbrc_pkg::ADDR_ONOFF_A &&
                        reg_addr <= lbrc_pkg::ADDR_ONOFF_H) begin
                        idx = reg_addr - lbrc_pkg::ADDR_ONOFF_A;
                        st_d.rdata = st_q.onoff[idx[2:0]];
                    end
                end
            endcase
        end

        // decoded ramp settings per bank, registered for clean outputs
        for (i = 0; i < 8; i++) begin
            st_d.onoff_o[i] = lbrc_ramp(1'b0, st_q.onoff[i]);
        end
        st_d.active_o[0] = lbrc_select(st_q.ab_sel[lbrc_pkg::SEL_A_LSB +: 2],
            st_q.ab_run, st_q.onoff[0]);
        st_d.active_o[1] = lbrc_select(st_q.ab_sel[lbrc_pkg::SEL_B_LSB +: 2],
            st_q.ab_run, st_q.onoff[1]);
        for (i = 2; i < 5; i++) begin
            st_d.active_o[i] = lbrc_ramp(1'b0, st_q.cde_run);
        end
        for (i = 5; i < 8; i++) begin
            st_d.active_o[i] = lbrc_ramp(1'b0, st_q.fgh_run);
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_q <= '0;
            st_q.hv_route <= lbrc_pkg::RST_HV_ROUTING;
            st_q.lv_route <= lbrc_pkg::RST_LV_ROUTING;
            st_q.dith_a_en <= 1'b1;
            st_q.dith_b_en <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // ==========================================================
    // outputs, all from flip-flops
    assign reg_rdata = st_q.rdata;
    assign soft_reset_pulse = st_q.srst;
    assign hv_sink_to_bank_b = st_q.hv_route[2:0];
    assign lv_sink_select = {st_q.lv_route[5:4], st_q.lv_route[2:1]};
    assign onoff_ramp = st_q.onoff_o;
    assign active_ramp = st_q.active_o;
    assign dither_a_en = st_q.dith_a_en;
    assign dither_b_en = st_q.dith_b_en;
    assign map_ab_linear = st_q.dmap[lbrc_pkg::MAP_AB_BIT];
    assign map_ch_linear = st_q.dmap[lbrc_pkg::MAP_CH_BIT];

endmodule

// File: lbrc_asserts.sv
// assertion checker for the led bank ramp configuration registers
`timescale 1ns/1ps
// ==========================================================
// checker
module lbrc_checker (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic soft_reset_pulse,
    input wire logic [2:0] hv_sink_to_bank_b,
    input wire logic [3:0] lv_sink_select,
    input wire lbrc_pkg::lbrc_ramp_s [7:0] onoff_ramp,
    input wire lbrc_pkg::lbrc_ramp_s [7:0] active_ramp,
    input wire logic dither_a_en,
    input wire logic dither_b_en,
    input wire logic map_ab_linear,
    input wire logic map_ch_linear
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // writes in the pulse cycle are dropped, so leave them out
    logic wr_ok;
    assign wr_ok = reg_wr && !soft_reset_pulse;
    a_rev_upper: assert property (
        reg_rd && reg_addr == 8'h00 |=> reg_rdata[7:4] == 4'h0)
        else $error("revision upper bits set");
    a_sreset_pulse: assert property (
        wr_ok && reg_addr == 8'h01 && reg_wdata[0]
        |=> soft_reset_pulse ##1 !soft_reset_pulse)
        else $error("soft reset pulse wrong");
    a_sreset_ramps: assert property (
        soft_reset_pulse |=> ##1 onoff_ramp == '0 && active_ramp == '0)
        else $error("ramps not cleared by soft reset");
    a_hv_route: assert property (
        wr_ok && reg_addr == 8'h10
        |=> hv_sink_to_bank_b == $past(reg_wdata[2:0]))
        else $error("high-voltage routing wrong");
    a_lv_route: assert property (
        wr_ok && reg_addr == 8'h11 |=> lv_sink_select ==
        {$past(reg_wdata[5:4]), $past(reg_wdata[2:1])})
        else $error("low-voltage routing wrong");
    a_narrow_onoff: assert property (
        wr_ok && reg_addr == 8'h14 |=> ##1
        onoff_ramp[2] == {1'b0, $past(reg_wdata, 2) & 8'h77})
        else $error("bank C ramp codes wrong");
    a_ramp_off: assert property (
        wr_ok && reg_addr == 8'h1B && reg_wdata[1]
        |=> ##1 active_ramp[0] == 9'h100)
        else $error("bank A ramp not disabled");
    a_dither_map: assert property (
        wr_ok && reg_addr == 8'h1F |=> {dither_b_en, dither_a_en,
        map_ch_linear, map_ab_linear} == ($past(reg_wdata[3:0]) ^ 4'hC))
        else $error("dither or mapping wrong");
endmodule

bind lbrc_top lbrc_checker u_chk (.*);

// File: lbrc_host.sv
// host model that drives the register port
`timescale 1ns/1ps
// ==========================================================
// host
module lbrc_host (
    input wire logic clk_sys,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // one request per cycle, so requests may follow with no gap
    task automatic op(input logic w, input logic r, input logic [7:0] a,
                      input logic [7:0] d);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
    endtask
endmodule

// File: tb_top.sv
// self-checking bench for the led bank ramp configuration registers
`timescale 1ns/1ps
module tb_top;
    localparam logic [3:0] REV = 4'h9; // arbitrary revision value
    logic clk_sys, rst, reg_wr, reg_rd, soft_reset_pulse;
    logic dither_a_en, dither_b_en, map_ab_linear, map_ch_linear;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [2:0] hv_sink_to_bank_b;
    logic [3:0] lv_sink_select;
    lbrc_pkg::lbrc_ramp_s [7:0] onoff_ramp, active_ramp;
    logic [7:0] mdl [32];
    logic [7:0] pats [3] = '{8'hFF, 8'h5A, 8'h25};
    int miscompares = 0;
    int check_count = 0;
    int cyc = 0;
    lbrc_top #(.SILICON_REV(REV)) i_dut (.clk_sys(clk_sys), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .soft_reset_pulse(soft_reset_pulse),
        .hv_sink_to_bank_b(hv_sink_to_bank_b),
        .lv_sink_select(lv_sink_select), .onoff_ramp(onoff_ramp),
        .active_ramp(active_ramp), .dither_a_en(dither_a_en),
        .dither_b_en(dither_b_en), .map_ab_linear(map_ab_linear),
        .map_ch_linear(map_ch_linear));
    lbrc_host i_host (.clk_sys(clk_sys), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // ==========================================================
    // register model
    function automatic logic [7:0] msk(input logic [7:0] a);
        case (a)
            8'h10: return 8'h07;
            8'h11: return 8'h36;
            8'h12, 8'h13, 8'h1A: return 8'hFF;
            8'h1B, 8'h1F: return 8'h0F;
            default: return (a inside {[8'h14:8'h19], 8'h1C, 8'h1D}) ?
                            8'h77 : 8'h00;
        endcase
    endfunction
    function automatic logic [8:0] act(input logic [1:0] s,
                                       input logic [7:0] oo);
        if (s[1]) return 9'h100;
        return {1'b0, s[0] ? oo : mdl[26]};
    endfunction
    task automatic mdl_rst();
        foreach (mdl[i]) mdl[i] = 8'h00;
        mdl[0] = {4'h0, REV};
        mdl[16] = 8'h06;
        mdl[17] = 8'h36;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_host.op(1'b1, 1'b0, a, d);
        if (a != 8'h00) mdl[a] = d & msk(a);
    endtask
    task automatic chk_outs();
        repeat (3) i_host.op(1'b0, 1'b0, 8'h00, 8'h00);
        chk(hv_sink_to_bank_b, mdl[16][2:0]);
        chk(lv_sink_select, {mdl[17][5:4], mdl[17][2:1]});
        chk({dither_b_en, dither_a_en, map_ch_linear, map_ab_linear},
            mdl[31][3:0] ^ 4'hC);
        for (int i = 0; i < 8; i++) begin
            chk(onoff_ramp[i], {1'b0, mdl[18 + i]});
            chk(active_ramp[i], i < 2 ? act(mdl[27][2*i +: 2], mdl[18 + i])
                : {1'b0, mdl[i < 5 ? 28 : 29]});
        end
    endtask
    // idle cycle after each read keeps the data cycle unambiguous
    task automatic chk_all();
        for (int a = 0; a < 32; a++) begin
            i_host.op(1'b0, 1'b1, 8'(a), 8'h00);
            i_host.op(1'b0, 1'b0, 8'(a), 8'h00);
            chk(reg_rdata, mdl[a]);
        end
        chk_outs();
    endtask
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            miscompares++;
            stop_test();
        end
    end
    // ==========================================================
    // tests
    initial begin
        rst = 1'b1;
        mdl_rst();
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        chk_all();
        foreach (pats[k]) begin
            for (int a = 0; a < 32; a++) if (a != 1) wr(8'(a), pats[k]);
            chk_all();
        end
        wr(8'h1A, 8'h3C);
        wr(8'h12, 8'h81);
        wr(8'h13, 8'h7E);
        for (int s = 0; s < 4; s++) begin
            wr(8'h1B, {4'h0, 2'(s), 2'(3 - s)});
            chk_outs();
        end
        // the write in the pulse cycle must be lost
        wr(8'h01, 8'h01);
        i_host.op(1'b1, 1'b0, 8'h1F, 8'h0F);
        chk(soft_reset_pulse, 1'b1);
        mdl_rst();
        chk_all();
        stop_test();
    end
endmodule
